// ### core/shf_pkg.sv
// Purpose: constants for the card host interrupt and fifo register bank
// Assumes: apb byte addresses, one aligned 32-bit word per register
// Notes: engine-side strobes are sampled on rising edges of the link clock
//
// Notes on behaviour
// - mask register, one bit per source at 7,6,5,2,1,0; one masks.
// - flag register shows pending requests; bits 15:8 and 4:3 reserved.
// - dma mode suppresses both fifo request interrupts; in pio mode the mask register decides whether they interrupt.
// - tx_refill_request is read-only, high while transmit fifo holds under eight.
// - rx_drain_request high at eight or more words, or final words held.
// - read-only bit 7 shows a detected sdio card interrupt.
// - bit 2 sets at command/response end; write one clears, zero ignored.
// - bit 1 sets when card leaves programming busy; write one clears.
// - bit 0 sets on transfer completion or error end; write one clears.
// - command index register holds six-bit index; bits 7:6 reserved.
// - command operand register is a full writable 32-bit field.
// - response queue is read-only, eight 16-bit entries, filled per command.
// - response queue holds no response crc; crc status lives elsewhere.
// - first response read returns most significant half-word, then less.
// - receive fifo sixteen 32-bit words, read-only, whole words only.
// - transmit fifo sixteen 32-bit words, write-only, whole words only.
// - dma enable bit selects dma or pio and masks fifo requests.
package shf_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_MASK = 8'h00;
  localparam logic [7:0] OFS_FLAGS = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_ARG = 8'h0c;
  localparam logic [7:0] OFS_RES = 8'h10;
  localparam logic [7:0] OFS_RXF = 8'h14;
  localparam logic [7:0] OFS_TXF = 8'h18;
  localparam logic [7:0] OFS_CTRL = 8'h1c;
  localparam logic [7:0] OFS_LEVEL = 8'h20;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int B_SDIO = 7;
  localparam int B_TXREQ = 6;
  localparam int B_RXREQ = 5;
  localparam int B_CMDEND = 2;
  localparam int B_PRG = 1;
  localparam int B_DONE = 0;
  localparam int C_DMA = 0;
  localparam int C_STREAM = 1;
  localparam int C_CLR = 2;
  localparam int CMD_W = 6;
  localparam logic [15:0] FLAG_BITS = 16'h00e7;
  localparam logic [15:0] W1C_BITS = 16'h0007;
  localparam logic [3:0] STRB_ALL = 4'hf;
  // ----------------------------------------
  // reset values and sizes
  // ----------------------------------------
  localparam logic [15:0] MASK_RST = 16'h00e7;
  localparam logic [5:0] CMD_RST = 6'h00;
  localparam logic [31:0] ARG_RST = 32'h0000_0000;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam int RES_W = 16;
  localparam int RES_DEPTH = 8;
  localparam int DATA_W = 32;
  localparam int DATA_DEPTH = 16;
  localparam int REQ_LEVEL = 8;
endpackage

// ### core/shf_sync.sv
// Purpose: two-flop synchroniser for a bundle of outside signals
// Assumes: multi-bit inputs are held steady across a link clock period
// Notes: only the second stage is visible outside
module shf_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ### core/shf_fifo.sv
// Purpose: flop-based fifo with occupancy count
// Assumes: push when full and pop when empty are ignored
// Notes: head word is visible without a pop
module shf_fifo #(
  parameter int W = 32,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic push,
  input wire logic [W-1:0] din,
  input wire logic pop,
  output logic [W-1:0] dout,
  output logic [$clog2(D):0] count,
  output logic full,
  output logic empty
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic do_push;
  logic do_pop;

  assign full = (cnt_r == (AW+1)'(D));
  assign empty = (cnt_r == '0);
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign dout = mem_r[rp_r];
  assign count = cnt_r;

  always_ff @(posedge clk)
  begin
    if (do_push)
      mem_r[wp_r] <= din;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else if (clr)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (do_push)
        wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
      if (do_pop)
        rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
      if (do_push && !do_pop)
        cnt_r <= cnt_r + 1'b1;
      else if (do_pop && !do_push)
        cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule

// ### core/shf_top.sv
// Purpose: interrupt, command and fifo registers of a card host controller
// Assumes: card engine drives its strobes from the falling link clock edge
// Notes: zero-wait apb slave; pready rises in the first access cycle
module shf_top #(
  parameter int RES_DEPTH = shf_pkg::RES_DEPTH,
  parameter int DATA_DEPTH = shf_pkg::DATA_DEPTH,
  parameter int REQ_LEVEL = shf_pkg::REQ_LEVEL
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_clk,
  input wire logic sdio_irq_n,
  input wire logic evt_cmd_done,
  input wire logic evt_card_programming_finished,
  input wire logic evt_data_done,
  input wire logic evt_data_err,
  input wire logic evt_stop_sent,
  input wire logic res_valid,
  input wire logic [15:0] res_half,
  input wire logic rx_valid,
  input wire logic [31:0] rx_word,
  input wire logic rx_last,
  input wire logic tx_take,
  output logic irq,
  output logic [5:0] cmd_index,
  output logic [31:0] cmd_operand,
  output logic [31:0] tx_word,
  output logic tx_empty,
  output logic rx_full,
  output logic dma_en,
  output logic stream_mode,
  output logic dma_tx_req,
  output logic dma_rx_req
);
  localparam int RW = shf_pkg::RES_W;
  localparam int DW = shf_pkg::DATA_W;
  localparam int SW = 59;
  localparam int RCW = $clog2(RES_DEPTH) + 1;
  localparam int DCW = $clog2(DATA_DEPTH) + 1;

  // ----------------------------------------
  // link side sampling
  // ----------------------------------------
  logic [SW-1:0] s_raw;
  logic [SW-1:0] s_q;
  logic lclk_s;
  logic lclk_d_r;
  logic lrise;
  logic sdio_s;
  logic e_cmd;
  logic e_prg;
  logic e_done;
  logic e_err;
  logic e_stop;
  logic e_res;
  logic [RW-1:0] e_half;
  logic e_rx;
  logic [DW-1:0] e_word;
  logic e_last;
  logic e_take;

  assign s_raw = {link_clk, ~sdio_irq_n, evt_cmd_done, evt_card_programming_finished, evt_data_done,
                  evt_data_err, evt_stop_sent, res_valid, res_half, rx_valid, rx_word,
                  rx_last, tx_take};

  shf_sync #(.W(SW)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(s_raw),
    .q(s_q)
  );

  assign {lclk_s, sdio_s, e_cmd, e_prg, e_done, e_err, e_stop, e_res, e_half,
          e_rx, e_word, e_last, e_take} = s_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lclk_d_r <= 1'b0;
    else
      lclk_d_r <= lclk_s;
  end

  // strobes only count on a sampled rising link edge, one event per link cycle
  assign lrise = lclk_s && !lclk_d_r;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic setup;
  logic acc;
  logic wr_acc;
  logic hit;
  logic bad;
  logic pend_wr_r;
  logic [7:0] pend_addr_r;
  logic pop_res_r;
  logic pop_rx_r;
  logic [31:0] rd_mux;

  function automatic logic addr_ok(input logic [7:0] a, input logic w, input logic [3:0] s);
    logic ok;
    ok = 1'b0;
    case (a)
      shf_pkg::OFS_MASK, shf_pkg::OFS_FLAGS, shf_pkg::OFS_CMD,
      shf_pkg::OFS_ARG, shf_pkg::OFS_CTRL:
        ok = 1'b1;
      shf_pkg::OFS_RES, shf_pkg::OFS_LEVEL:
        ok = !w;
      shf_pkg::OFS_RXF:
        ok = !w;
      shf_pkg::OFS_TXF:
        ok = w && (s == shf_pkg::STRB_ALL);
      default:
        ok = 1'b0;
    endcase
    return ok;
  endfunction

  assign setup = psel && !penable;
  assign acc = psel && penable && pready;
  assign hit = addr_ok(paddr, pwrite, pstrb);
  assign bad = !hit;
  assign wr_acc = acc && pend_wr_r && !pslverr;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      pend_wr_r <= 1'b0;
      pend_addr_r <= 8'h00;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && bad;
      if (setup)
      begin
        pend_wr_r <= pwrite;
        pend_addr_r <= paddr;
      end
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  logic [15:0] mask_r;
  logic fifo_clr;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_r <= shf_pkg::MASK_RST;
    else if (wr_acc && pend_addr_r == shf_pkg::OFS_MASK)
      mask_r <= pwdata[15:0] & shf_pkg::FLAG_BITS;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmd_index <= shf_pkg::CMD_RST;
    else if (wr_acc && pend_addr_r == shf_pkg::OFS_CMD)
      cmd_index <= pwdata[shf_pkg::CMD_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmd_operand <= shf_pkg::ARG_RST;
    else if (wr_acc && pend_addr_r == shf_pkg::OFS_ARG)
      cmd_operand <= pwdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dma_en <= shf_pkg::CTRL_RST[shf_pkg::C_DMA];
      stream_mode <= shf_pkg::CTRL_RST[shf_pkg::C_STREAM];
    end
    else if (wr_acc && pend_addr_r == shf_pkg::OFS_CTRL)
    begin
      dma_en <= pwdata[shf_pkg::C_DMA];
      stream_mode <= pwdata[shf_pkg::C_STREAM];
    end
  end

  // write-one pulse empties all three fifos before a new transfer
  assign fifo_clr = wr_acc && pend_addr_r == shf_pkg::OFS_CTRL && pwdata[shf_pkg::C_CLR];

  // ----------------------------------------
  // fifos
  // ----------------------------------------
  logic [RW-1:0] res_head;
  logic [RCW-1:0] res_cnt;
  logic res_emp;
  logic [DW-1:0] rx_head;
  logic [DCW-1:0] rx_cnt;
  logic rx_emp;
  logic rx_ful;
  logic [DW-1:0] tx_head;
  logic [DCW-1:0] tx_cnt;
  logic tx_emp;
  logic tx_push;
  logic tx_pop;

  // engine delivers halves msb first without crc; order is kept as pushed
  shf_fifo #(.W(RW), .D(RES_DEPTH)) u_res (
    .clk(pclk),
    .rst_n(presetn),
    .clr(fifo_clr),
    .push(lrise && e_res),
    .din(e_half),
    .pop(acc && pop_res_r),
    .dout(res_head),
    .count(res_cnt),
    .full(),
    .empty(res_emp)
  );

  shf_fifo #(.W(DW), .D(DATA_DEPTH)) u_rx (
    .clk(pclk),
    .rst_n(presetn),
    .clr(fifo_clr),
    .push(lrise && e_rx),
    .din(e_word),
    .pop(acc && pop_rx_r),
    .dout(rx_head),
    .count(rx_cnt),
    .full(rx_ful),
    .empty(rx_emp)
  );

  assign tx_push = wr_acc && pend_addr_r == shf_pkg::OFS_TXF;
  assign tx_pop = lrise && e_take && !tx_emp;

  shf_fifo #(.W(DW), .D(DATA_DEPTH)) u_tx (
    .clk(pclk),
    .rst_n(presetn),
    .clr(fifo_clr),
    .push(tx_push),
    .din(pwdata),
    .pop(tx_pop),
    .dout(tx_head),
    .count(tx_cnt),
    .full(),
    .empty(tx_emp)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_word <= 32'h0000_0000;
      tx_empty <= 1'b1;
      rx_full <= 1'b0;
    end
    else
    begin
      if (tx_pop)
        tx_word <= tx_head;
      tx_empty <= tx_emp;
      rx_full <= rx_ful;
    end
  end

  // ----------------------------------------
  // flags
  // ----------------------------------------
  logic [2:0] sticky_r;
  logic [2:0] set_ev;
  logic [2:0] clr_ev;
  logic last_r;
  logic tx_req;
  logic rx_req;
  logic sdio_r;
  logic [15:0] flags;
  logic [15:0] live;

  assign set_ev[shf_pkg::B_CMDEND] = lrise && e_cmd;
  assign set_ev[shf_pkg::B_PRG] = lrise && e_prg;
  // stream transfers end once the stop command went out, not at data done; an error ends any transfer
  assign set_ev[shf_pkg::B_DONE] = lrise && (e_err || (stream_mode ? e_stop : e_done));
  assign clr_ev = (wr_acc && pend_addr_r == shf_pkg::OFS_FLAGS) ?
                  pwdata[2:0] & shf_pkg::W1C_BITS[2:0] : 3'h0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sticky_r <= 3'h0;
    else
      sticky_r <= set_ev | (sticky_r & ~clr_ev);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      last_r <= 1'b0;
    else if (fifo_clr)
      last_r <= 1'b0;
    // the tagged push lands while the fifo still reads empty, so it must win
    else if (lrise && e_rx && e_last)
      last_r <= 1'b1;
    else if (rx_emp)
      last_r <= 1'b0;
  end

  assign tx_req = tx_cnt < DCW'(REQ_LEVEL);
  assign rx_req = (rx_cnt >= DCW'(REQ_LEVEL)) || (last_r && !rx_emp);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sdio_r <= 1'b0;
    else
      sdio_r <= sdio_s;
  end

  always_comb
  begin
    live = 16'h0000;
    live[shf_pkg::B_SDIO] = sdio_r;
    live[shf_pkg::B_TXREQ] = tx_req;
    live[shf_pkg::B_RXREQ] = rx_req;
    live[2:0] = sticky_r;
  end

  assign flags = live & shf_pkg::FLAG_BITS;

  // ----------------------------------------
  // interrupt and dma requests
  // ----------------------------------------
  logic [15:0] gate;

  always_comb
  begin
    gate = ~mask_r;
    if (dma_en)
    begin
      gate[shf_pkg::B_TXREQ] = 1'b0;
      gate[shf_pkg::B_RXREQ] = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq <= 1'b0;
      dma_tx_req <= 1'b0;
      dma_rx_req <= 1'b0;
    end
    else
    begin
      irq <= |(flags & gate);
      dma_tx_req <= dma_en && tx_req;
      dma_rx_req <= dma_en && rx_req;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      shf_pkg::OFS_MASK:
        rd_mux = {16'h0000, mask_r};
      shf_pkg::OFS_FLAGS:
        rd_mux = {16'h0000, flags};
      shf_pkg::OFS_CMD:
        rd_mux = {26'h0, cmd_index};
      shf_pkg::OFS_ARG:
        rd_mux = cmd_operand;
      shf_pkg::OFS_RES:
        rd_mux = res_emp ? 32'h0000_0000 : {16'h0000, res_head};
      shf_pkg::OFS_RXF:
        rd_mux = rx_emp ? 32'h0000_0000 : rx_head;
      shf_pkg::OFS_CTRL:
        rd_mux = {30'h0, stream_mode, dma_en};
      shf_pkg::OFS_LEVEL:
        rd_mux = {8'h00, 8'(res_cnt), 8'(rx_cnt), 8'(tx_cnt)};
      default:
        rd_mux = 32'h0000_0000;
    endcase
  end

  // pop only what was shown at setup, a word pushed later stays queued
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pop_res_r <= 1'b0;
      pop_rx_r <= 1'b0;
    end
    else if (setup)
    begin
      prdata <= (!pwrite && hit) ? rd_mux : 32'h0000_0000;
      pop_res_r <= !pwrite && paddr == shf_pkg::OFS_RES && !res_emp;
      pop_rx_r <= !pwrite && paddr == shf_pkg::OFS_RXF && !rx_emp;
    end
    else if (acc)
    begin
      pop_res_r <= 1'b0;
      pop_rx_r <= 1'b0;
    end
  end
endmodule

// ### bench/shf_top_asserts.sv
// Purpose: port checks for the card host register bank
// Assumes: zero-wait apb slave, full strobes on fifo pushes
// Notes: bound to shf_top at the foot of this file
module shf_top_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [5:0] cmd_index,
  input wire logic [31:0] cmd_operand,
  input wire logic tx_empty,
  input wire logic rx_full,
  input wire logic dma_en,
  input wire logic stream_mode,
  input wire logic dma_tx_req,
  input wire logic dma_rx_req
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic wr_ok;
  logic set_w;
  logic set_r;
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  assign set_w = psel && !penable && pwrite;
  assign set_r = psel && !penable && !pwrite;
  // ----------------------------------------
  // register writes
  // ----------------------------------------
  a_operand_write: assert property (
    wr_ok && paddr == shf_pkg::OFS_ARG |=> cmd_operand == $past(pwdata))
    else $error("operand register missed a write");
  a_index_write: assert property (
    wr_ok && paddr == shf_pkg::OFS_CMD |=> cmd_index == $past(pwdata[5:0]))
    else $error("command index missed a write");
  a_ctrl_write: assert property (
    wr_ok && paddr == shf_pkg::OFS_CTRL |=> {stream_mode, dma_en} == $past(pwdata[1:0]))
    else $error("mode bits missed a write");
  // ----------------------------------------
  // refusals and fifos
  // ----------------------------------------
  a_tx_no_read: assert property (
    set_r && paddr == shf_pkg::OFS_TXF |=> pready && pslverr)
    else $error("transmit fifo read not refused");
  a_rx_no_write: assert property (
    set_w && paddr == shf_pkg::OFS_RXF |-> ##1 pready ##0 pslverr)
    else $error("receive fifo write not refused");
  a_res_no_write: assert property (
    set_w && paddr == shf_pkg::OFS_RES |=> pslverr)
    else $error("response fifo write not refused");
  a_tx_push: assert property (
    wr_ok && paddr == shf_pkg::OFS_TXF && pstrb == shf_pkg::STRB_ALL |-> ##[1:2] !tx_empty)
    else $error("transmit push left fifo empty");
  // ----------------------------------------
  // dma requests
  // ----------------------------------------
  a_dma_tx: assert property ((dma_en && tx_empty) [*3] |-> dma_tx_req)
    else $error("dma refill request missing");
  a_dma_rx: assert property ((dma_en && rx_full) [*3] |-> dma_rx_req)
    else $error("dma drain request missing");
  a_dma_off: assert property ($fell(dma_en) |=> !dma_tx_req && !dma_rx_req)
    else $error("dma request outlived dma mode");
  c_refused: cover property (pready && pslverr);
  c_rx_full: cover property (rx_full && dma_rx_req);
  c_dma_tx: cover property (dma_tx_req);
endmodule

bind shf_top shf_top_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .pready, .pslverr, .cmd_index, .cmd_operand, .tx_empty, .rx_full,
  .dma_en, .stream_mode, .dma_tx_req, .dma_rx_req);

// ### bench/shf_card_model.sv
// Purpose: card engine stand-in on the link side of shf_top
// Assumes: one beat per link period, link clock idle low between beats
// Notes: released data lines show the inverse of the last value
module shf_card_model (
  output logic link_clk,
  output logic sdio_irq_n,
  output logic evt_cmd_done,
  output logic evt_card_programming_finished,
  output logic evt_data_done,
  output logic evt_data_err,
  output logic evt_stop_sent,
  output logic res_valid,
  output logic [15:0] res_half,
  output logic rx_valid,
  output logic [31:0] rx_word,
  output logic rx_last,
  output logic tx_take
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] ev_q;
  assign {tx_take, rx_last, rx_valid, res_valid, evt_stop_sent, evt_data_err,
    evt_data_done, evt_card_programming_finished, evt_cmd_done} = ev_q;
  initial
  begin
    link_clk = 1'b0;
    sdio_irq_n = 1'b1;
    ev_q = '0;
    res_half = '0;
    rx_word = '0;
  end
  task automatic set_sdio(input logic v);
    sdio_irq_n = v;
  endtask
  // change at the fall so the rise sees settled lines; odd offset keeps phase unrelated
  task automatic beat(input logic [8:0] ev, input logic [15:0] h, input logic [31:0] w);
    #2.3;
    ev_q = ev;
    res_half = h;
    rx_word = w;
    #40 link_clk = 1'b1;
    #40 link_clk = 1'b0;
    ev_q = '0;
    res_half = ~h;
    rx_word = ~w;
  endtask
endmodule

// ### bench/shf_top_tb.sv
// Purpose: self-checking bench for shf_top
// Assumes: zero-wait apb slave, card model on the link side
// Notes: seeded random data, corner cases by hand
`define CHK(nm, exp, got) \
  begin tests_run++; if ((got) !== (exp)) begin error_cnt++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module shf_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [8:0] E_CMD = 9'h001;
  localparam logic [8:0] E_PRG = 9'h002;
  localparam logic [8:0] E_DONE = 9'h004;
  localparam logic [8:0] E_ERR = 9'h008;
  localparam logic [8:0] E_STOP = 9'h010;
  localparam logic [8:0] E_RES = 9'h020;
  localparam logic [8:0] E_RXV = 9'h040;
  localparam logic [8:0] E_LAST = 9'h080;
  localparam logic [8:0] E_TAKE = 9'h100;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, cmd_operand, tx_word, rx_word, rd_v, v;
  logic [3:0] pstrb, strb;
  logic [5:0] cmd_index;
  logic [15:0] res_half;
  logic link_clk, sdio_irq_n, evt_cmd_done, evt_card_programming_finished, evt_data_done, evt_data_err;
  logic evt_stop_sent, res_valid, rx_valid, rx_last, tx_take, err_v;
  logic tx_empty, rx_full, dma_en, stream_mode, dma_tx_req, dma_rx_req;
  int error_cnt, tests_run, i, j, seed;
  logic [7:0] ra [5] = '{8'h00, 8'h08, 8'h0c, 8'h1c, 8'h04};
  logic [31:0] re [5] = '{32'h00e7, 32'h0, 32'h0, 32'h0, 32'h0040};
  logic [8:0] rf [6] = '{9'h018, 9'h114, 9'h110, 9'h120, 9'h024, 9'h1fc};
  logic [8:0] ev [4] = '{E_CMD, E_PRG, E_DONE, E_ERR};
  logic [31:0] fl [4] = '{32'h4, 32'h2, 32'h1, 32'h1};
  logic [15:0] hv [9];
  logic [31:0] xv [17];
  shf_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .link_clk, .sdio_irq_n, .evt_cmd_done, .evt_card_programming_finished, .evt_data_done,
    .evt_data_err, .evt_stop_sent, .res_valid, .res_half, .rx_valid, .rx_word, .rx_last,
    .tx_take, .irq, .cmd_index, .cmd_operand, .tx_word, .tx_empty, .rx_full, .dma_en,
    .stream_mode, .dma_tx_req, .dma_rx_req);
  shf_card_model card (.link_clk, .sdio_irq_n, .evt_cmd_done, .evt_card_programming_finished, .evt_data_done,
    .evt_data_err, .evt_stop_sent, .res_valid, .res_half, .rx_valid, .rx_word, .rx_last,
    .tx_take);
  function automatic logic [31:0] rw_exp(input logic [7:0] a, input logic [31:0] d);
    case (a)
      shf_pkg::OFS_MASK: return d & 32'h00e7;
      shf_pkg::OFS_CMD: return d & 32'h003f;
      shf_pkg::OFS_CTRL: return d & 32'h0003;
      default: return d;
    endcase
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= strb;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20)
    begin
      error_cnt++;
      $display("ERROR pready expected 1 seen %b", pready);
    end
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // a run of about 6.4 us; the margin covers slow beats
  initial
  begin
    #60000;
    error_cnt++;
    $display("ERROR watchdog expected end seen hang");
    finish_test();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    strb = 4'hf;
    pstrb = 4'hf;
    seed = $urandom(90415);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 5; i++)
    begin
      rd(ra[i]);
      `CHK("reset", re[i], rd_v)
    end
    for (j = 0; j < 12; j++)
    begin
      v = $urandom;
      wr(ra[j % 4], v);
      rd(ra[j % 4]);
      `CHK("readback", rw_exp(ra[j % 4], v), rd_v)
    end
    wr(shf_pkg::OFS_CTRL, 32'h0);
    for (i = 0; i < 6; i++)
    begin
      apb(rf[i][8], rf[i][7:0], $urandom);
      `CHK("refused", 1'b1, err_v)
    end
    strb = 4'h3;
    wr(shf_pkg::OFS_TXF, 32'h1234_5678);
    `CHK("part strobe", 1'b1, err_v)
    `CHK("tx empty", 1'b1, tx_empty)
    strb = 4'hf;
    wr(shf_pkg::OFS_MASK, 32'h00e0);
    for (i = 0; i < 4; i++)
    begin
      card.beat(ev[i], 16'h0, 32'h0);
      rd(shf_pkg::OFS_FLAGS);
      `CHK("flag set", fl[i], rd_v & 32'h7)
      `CHK("irq on", 1'b1, irq)
      wr(shf_pkg::OFS_FLAGS, 32'h0);
      rd(shf_pkg::OFS_FLAGS);
      `CHK("flag kept", fl[i], rd_v & 32'h7)
      wr(shf_pkg::OFS_FLAGS, fl[i]);
      rd(shf_pkg::OFS_FLAGS);
      `CHK("flag clear", 32'h0, rd_v & 32'h7)
      `CHK("irq off", 1'b0, irq)
    end
    wr(shf_pkg::OFS_CTRL, 32'h2);
    card.beat(E_DONE, 16'h0, 32'h0);
    rd(shf_pkg::OFS_FLAGS);
    `CHK("stream early", 1'b0, rd_v[0])
    card.beat(E_STOP, 16'h0, 32'h0);
    rd(shf_pkg::OFS_FLAGS);
    `CHK("stream done", 1'b1, rd_v[0])
    wr(shf_pkg::OFS_FLAGS, 32'h1);
    wr(shf_pkg::OFS_CTRL, 32'h0);
    for (i = 0; i < 9; i++)
    begin
      hv[i] = 16'($urandom);
      card.beat(E_RES, hv[i], 32'h0);
    end
    for (i = 0; i < 9; i++)
    begin
      rd(shf_pkg::OFS_RES);
      `CHK("response", (i < 8) ? {16'h0, hv[i]} : 32'h0, rd_v)
    end
    for (i = 0; i < 17; i++)
    begin
      rd(shf_pkg::OFS_FLAGS);
      `CHK("tx request", i < 8, rd_v[6])
      xv[i] = $urandom;
      wr(shf_pkg::OFS_TXF, xv[i]);
    end
    for (i = 0; i < 16; i++)
    begin
      card.beat(E_TAKE, 16'h0, 32'h0);
      `CHK("tx word", xv[i], tx_word)
    end
    `CHK("tx drained", 1'b1, tx_empty)
    for (i = 0; i < 17; i++)
    begin
      rd(shf_pkg::OFS_FLAGS);
      `CHK("rx request", i >= 8, rd_v[5])
      xv[i] = $urandom;
      card.beat(E_RXV, 16'h0, xv[i]);
    end
    `CHK("rx full", 1'b1, rx_full)
    wr(shf_pkg::OFS_CTRL, 32'h1);
    rd(shf_pkg::OFS_CTRL);
    `CHK("dma rx", 1'b1, dma_rx_req)
    for (i = 0; i < 16; i++)
    begin
      rd(shf_pkg::OFS_RXF);
      `CHK("rx word", xv[i], rd_v)
    end
    wr(shf_pkg::OFS_CTRL, 32'h0);
    card.beat(E_RXV | E_LAST, 16'h0, 32'h5a5a_0f0f);
    rd(shf_pkg::OFS_FLAGS);
    `CHK("rx last", 1'b1, rd_v[5])
    rd(shf_pkg::OFS_RXF);
    `CHK("rx last word", 32'h5a5a_0f0f, rd_v)
    wr(shf_pkg::OFS_MASK, 32'h00a7);
    rd(shf_pkg::OFS_CTRL);
    `CHK("pio irq", 1'b1, irq)
    wr(shf_pkg::OFS_CTRL, 32'h1);
    rd(shf_pkg::OFS_CTRL);
    `CHK("dma irq", 1'b0, irq)
    `CHK("dma tx", 1'b1, dma_tx_req)
    wr(shf_pkg::OFS_CTRL, 32'h0);
    wr(shf_pkg::OFS_MASK, 32'h0067);
    card.set_sdio(1'b0);
    repeat (6) @(posedge pclk);
    rd(shf_pkg::OFS_FLAGS);
    `CHK("sdio flag", 1'b1, rd_v[7])
    `CHK("sdio irq", 1'b1, irq)
    finish_test();
  end
endmodule
